// >>> design/vadf_pkg.sv
// Purpose: Constants and types for the frame-rate voice activity detector
// Assumes: One frame strobe per 20 ms encoder frame, 40 MHz clock
// Notes:   Fixed-point: coefs Q12, distortion Q12, acf signed 32 bit
// Summary of operation
// - one speech/noise flag per 20 ms frame
// - energy = c0*acf0 + 2*sum ci*acfi
// - recent average sums four latest frames
// - delayed average is recent of four earlier
// - solve eighth-order normal equations, a0 = -1
// - candidate coefs are predictor autocorrelation
// - distortion from candidates and recent average
// - difference to stored distortion, then store
// - stationary when difference below 0.05
// - adapt only stationary, aperiodic, tone-free
// - fixed low-level threshold blocks noise speech
// - speech when energy exceeds threshold
// - raw decision: energy strictly above threshold
// - hangover 5 frames after 3-frame bursts
package vadf_pkg;
    localparam int NLAG        = 9;
    localparam int ACF_W       = 32;
    localparam int AVG_W       = 34;
    localparam int COEF_W      = 16;
    localparam int COEF_FRAC   = 12;
    localparam int ACC_W       = 72;
    localparam int FRAMES      = 4;
    localparam int FRAME_MS    = 20;
    localparam int CLK_KHZ     = 40000;
    localparam int FRAME_CYC   = FRAME_MS * CLK_KHZ;
    // 0.05 in Q12, rounded down so a tie is not stationary
    localparam logic [31:0] STAT_THRESH = 32'h0000_00CC;
    localparam logic [3:0]  BURST_CONST = 4'h3;
    localparam logic [3:0]  HANG_CONST  = 4'h5;
    localparam logic [3:0]  ADAPT_FRAMES = 4'h8;
    localparam logic [ACC_W-1:0] THR_INIT  = 72'h00_0000_0000_000F_4240;
    localparam logic [ACC_W-1:0] FIX_THR   = 72'h00_0000_0000_000C_3500;
    localparam logic [ACC_W-1:0] LOW_PWR   = 72'h00_0000_0000_0004_93E0;
    // Adaptive filter reset values 6, -4, 1 in Q12
    localparam logic [COEF_W-1:0] RV0_INIT = 16'h6000;
    localparam logic [COEF_W-1:0] RV1_INIT = 16'hC000;
    localparam logic [COEF_W-1:0] RV2_INIT = 16'h1000;
    localparam logic [COEF_W-1:0] A0_INIT  = 16'hF000;
    typedef logic signed [ACF_W-1:0]  vadf_acf_t  [NLAG];
    typedef logic signed [AVG_W-1:0]  vadf_avg_t  [NLAG];
    typedef logic signed [COEF_W-1:0] vadf_coef_t [NLAG];
    typedef struct packed {
        logic       speech;
        logic       raw_speech;
        logic       stationary;
    } vadf_flags_s;
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_AVG   = 3'b001,
        ST_SOLVE = 3'b010,
        ST_CAND  = 3'b011,
        ST_DIST  = 3'b100,
        ST_DONE  = 3'b101
    } vadf_state_e;
endpackage

// >>> design/vadf_lev.sv
`timescale 1ns/1ps
// Purpose: Sequential Levinson solver for the 8th-order normal equations
// Assumes: Start pulse with stable delayed average until done
// Notes:   Coefs Q12; a lag-zero input of zero or less gives a flat predictor
module vadf_lev
    import vadf_pkg::*;
(
    // Clock and reset
    input  wire logic               sys_clk,
    input  wire logic               rst_n,
    // Request
    input  wire logic               start,
    input  wire logic [AVG_W*NLAG-1:0] r_flat,
    // Answer
    output logic                    done,
    output logic [COEF_W*NLAG-1:0]  a_flat
);
    logic signed [63:0] a [NLAG];
    logic signed [63:0] err;
    logic [3:0]         m;
    logic               busy;
    logic signed [63:0] acc;
    logic signed [63:0] k;
    logic signed [AVG_W-1:0] rv [NLAG];

    always_comb begin
        for (int i = 0; i < NLAG; i++)
            rv[i] = r_flat[i*AVG_W +: AVG_W];
        acc = 64'(rv[m]);
        for (int j = 1; j < NLAG; j++)
            if (j < m)
                acc = acc - ((a[j] * 64'(rv[m-j])) >>> COEF_FRAC);
        k = (err > 0) ? (acc <<< COEF_FRAC) / err : 64'sh0;
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            busy <= 1'b0;
            done <= 1'b0;
            m    <= 4'h0;
            err  <= 64'h0;
            for (int i = 0; i < NLAG; i++)
                a[i] <= 64'h0;
        end else begin
            done <= 1'b0;
            if (start) begin
                busy <= 1'b1;
                m    <= 4'h1;
                err  <= 64'(rv[0]);
                for (int i = 0; i < NLAG; i++)
                    a[i] <= 64'h0;
            end else if (busy) begin
                for (int j = 1; j < NLAG; j++)
                    if (j < m)
                        a[j] <= a[j] - ((k * a[m-j]) >>> COEF_FRAC);
                a[m] <= k;
                err  <= err - ((k * k * err) >>> (2*COEF_FRAC));
                // Order held at eight so idle lookups stay in range
                if (m == 4'h8) begin
                    busy <= 1'b0;
                    done <= 1'b1;
                end else begin
                    m <= m + 4'h1;
                end
            end
        end
    end

    // Coefficient zero fixed at minus one; others cut to Q12
    always_comb begin
        a_flat[0 +: COEF_W] = A0_INIT;
        for (int i = 1; i < NLAG; i++)
            a_flat[i*COEF_W +: COEF_W] = COEF_W'(a[i]);
    end
endmodule

// >>> design/vadf_top.sv
`timescale 1ns/1ps
// Purpose: Frame-rate voice activity detector core
// Assumes: Encoder raises frame_valid once per frame with acf stable
// Notes:   Periodicity and tone flags come from outside as levels
module vadf_top
    import vadf_pkg::*;
(
    // Clock and reset
    input  wire logic                  sys_clk,
    input  wire logic                  rst_n,
    // Encoder frame input
    input  wire logic                  frame_valid,
    input  wire logic [ACF_W*NLAG-1:0] acf_flat,
    input  wire logic                  pitch_seen,
    input  wire logic                  tone_seen,
    // Decision output
    output vadf_flags_s                flags,
    output logic                       frame_done,
    output logic [ACC_W-1:0]           filt_energy
);
    vadf_state_e state;
    logic signed [ACF_W-1:0]  acf [NLAG];
    logic signed [ACF_W-1:0]  hist [FRAMES-1][NLAG];
    vadf_avg_t                recent_acf_avg;
    logic signed [AVG_W-1:0]  avg_pipe [FRAMES-1][NLAG];
    vadf_avg_t                delayed_acf_avg;
    vadf_coef_t               rvad;
    vadf_coef_t               predictor_coefs;
    logic signed [31:0]       candidate_coefs [NLAG];
    logic signed [31:0]       distortion_value;
    logic signed [31:0]       next_dist;
    logic [ACC_W-1:0]         threshold;
    logic [3:0]               adapt_cnt;
    logic [3:0]               burst_cnt;
    logic signed [3:0]        hang_cnt;
    logic                     lev_start;
    logic                     lev_done;
    logic [AVG_W*NLAG-1:0]    r_flat;
    logic [COEF_W*NLAG-1:0]   a_flat;
    logic signed [ACC_W-1:0]  energy;
    logic signed [ACC_W-1:0]  dnum;
    logic                     stat;
    logic                     raw;

    // Weighted correlation: w0*v0 + 2*sum wi*vi, used twice
    function automatic logic signed [ACC_W-1:0] wsum(
        input logic signed [31:0]      w [NLAG],
        input logic signed [AVG_W-1:0] v [NLAG]);
        logic signed [ACC_W-1:0] s;
        s = ACC_W'(w[0]) * ACC_W'(v[0]);
        for (int i = 1; i < NLAG; i++)
            s = s + 2 * (ACC_W'(w[i]) * ACC_W'(v[i]));
        return s;
    endfunction

    always_comb begin
        logic signed [31:0]      wr [NLAG];
        logic signed [AVG_W-1:0] va [NLAG];
        wr = '{default: '0};
        va = '{default: '0};
        for (int i = 0; i < NLAG; i++) begin
            acf[i] = acf_flat[i*ACF_W +: ACF_W];
            wr[i]  = 32'(rvad[i]);
            va[i]  = AVG_W'(acf[i]);
            r_flat[i*AVG_W +: AVG_W] = delayed_acf_avg[i];
            predictor_coefs[i] = a_flat[i*COEF_W +: COEF_W];
        end
        energy = wsum(wr, va) >>> COEF_FRAC;
        dnum   = wsum(candidate_coefs, recent_acf_avg);
        next_dist = (recent_acf_avg[0] > 0) ?
            32'(dnum / ACC_W'(recent_acf_avg[0])) : 32'h0;
    end

    // Sequencer, one pass per strobe
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state     <= ST_IDLE;
            lev_start <= 1'b0;
        end else begin
            lev_start <= 1'b0;
            unique case (state)
                ST_IDLE:  if (frame_valid) state <= ST_AVG;
                ST_AVG: begin
                    lev_start <= 1'b1;
                    state     <= ST_SOLVE;
                end
                ST_SOLVE: if (lev_done) state <= ST_CAND;
                ST_CAND:  state <= ST_DIST;
                ST_DIST:  state <= ST_DONE;
                ST_DONE:  state <= ST_IDLE;
                default:  state <= ST_IDLE;
            endcase
        end
    end

    // Averages and delay line
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < NLAG; i++) begin
                recent_acf_avg[i]  <= '0;
                delayed_acf_avg[i] <= '0;
                for (int f = 0; f < FRAMES-1; f++)
                    hist[f][i] <= '0;
                for (int f = 0; f < FRAMES-1; f++)
                    avg_pipe[f][i] <= '0;
            end
        end else if (state == ST_IDLE && frame_valid) begin
            for (int i = 0; i < NLAG; i++) begin
                recent_acf_avg[i] <= AVG_W'(acf[i]) + AVG_W'(hist[0][i])
                    + AVG_W'(hist[1][i]) + AVG_W'(hist[2][i]);
                hist[0][i] <= acf[i];
                for (int f = 1; f < FRAMES-1; f++)
                    hist[f][i] <= hist[f-1][i];
                // Pipe holds the three previous averages, so the
                // delayed one is the average of four frames back
                avg_pipe[0][i] <= recent_acf_avg[i];
                for (int f = 1; f < FRAMES-1; f++)
                    avg_pipe[f][i] <= avg_pipe[f-1][i];
                delayed_acf_avg[i] <= avg_pipe[FRAMES-2][i];
            end
        end
    end

    // Candidate coefficients from predictor autocorrelation
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < NLAG; i++)
                candidate_coefs[i] <= '0;
        end else if (state == ST_CAND) begin
            for (int i = 0; i < NLAG; i++) begin
                logic signed [31:0] s;
                s = '0;
                for (int k = 0; k < NLAG; k++)
                    if (k + i < NLAG)
                        s = s + ((32'(predictor_coefs[k])
                            * 32'(predictor_coefs[k+i])) >>> COEF_FRAC);
                candidate_coefs[i] <= s;
            end
        end
    end

    // Spectral comparison
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            distortion_value <= '0;
            stat             <= 1'b0;
        end else if (state == ST_DIST) begin
            logic signed [31:0] d;
            d = next_dist - distortion_value;
            stat <= ((d < 0 ? -d : d) < $signed(STAT_THRESH));
            distortion_value <= next_dist;
        end
    end

    // Threshold and filter adaptation
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            threshold <= THR_INIT;
            adapt_cnt <= 4'h0;
            for (int i = 0; i < NLAG; i++)
                rvad[i] <= '0;
            rvad[0] <= RV0_INIT;
            rvad[1] <= RV1_INIT;
            rvad[2] <= RV2_INIT;
        end else if (state == ST_DONE) begin
            if (ACC_W'(acf[0]) < LOW_PWR) begin
                threshold <= FIX_THR;
            end else if (stat && !pitch_seen && !tone_seen) begin
                if (adapt_cnt == ADAPT_FRAMES) begin
                    for (int i = 0; i < NLAG; i++)
                        rvad[i] <= COEF_W'(candidate_coefs[i]);
                    threshold <= (energy > 0) ? 3 * energy : FIX_THR;
                    adapt_cnt <= 4'h0;
                end else begin
                    adapt_cnt <= adapt_cnt + 4'h1;
                end
            end else begin
                adapt_cnt <= 4'h0;
            end
        end
    end

    // Decision with fixed floor and hangover
    always_comb begin
        raw = energy > $signed(threshold)
            && energy > $signed(FIX_THR);
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            burst_cnt   <= 4'h0;
            hang_cnt    <= -4'sd1;
            flags       <= '0;
            frame_done  <= 1'b0;
            filt_energy <= '0;
        end else begin
            frame_done <= 1'b0;
            if (state == ST_DONE) begin
                logic [3:0]        b;
                logic signed [3:0] h;
                b = raw ? burst_cnt + 4'h1 : 4'h0;
                h = hang_cnt;
                if (b >= BURST_CONST) begin
                    h = $signed(HANG_CONST);
                    b = BURST_CONST;
                end
                flags.speech     <= raw || (h >= 0);
                flags.raw_speech <= raw;
                flags.stationary <= stat;
                hang_cnt    <= (h >= 0) ? h - 4'sd1 : h;
                burst_cnt   <= b;
                frame_done  <= 1'b1;
                filt_energy <= energy;
            end
        end
    end

    vadf_lev u_lev (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .start   (lev_start),
        .r_flat  (r_flat),
        .done    (lev_done),
        .a_flat  (a_flat)
    );

    done_pulse_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        frame_done |-> $past(state) == ST_DONE)
        else $error("Done pulse without a pass");
    raw_energy_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        frame_done |-> flags.raw_speech ==
            ($signed(filt_energy) > $signed($past(threshold))
            && $signed(filt_energy) > $signed(FIX_THR)))
        else $error("Raw decision disagrees with energy");
    pass_latency_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        state == ST_IDLE && frame_valid |-> ##15 frame_done)
        else $error("Frame pass latency wrong");
    done_single_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        frame_done |=> !frame_done)
        else $error("Done pulse longer than one cycle");
    raw_speech_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        frame_done && flags.raw_speech |-> flags.speech)
        else $error("Raw speech lost");
    pass_bound_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        state == ST_AVG |-> ##[4:20] frame_done)
        else $error("Pass too slow");
    cp_speech: cover property (@(posedge sys_clk) frame_done && flags.speech);
    cp_hang: cover property (@(posedge sys_clk)
        frame_done && flags.speech && !flags.raw_speech);
    cp_stat: cover property (@(posedge sys_clk)
        frame_done && flags.stationary);
endmodule

// >>> test/vadf_enc_model.sv
`timescale 1ns/1ps
// Purpose: Speech encoder stand-in, one acf set per frame strobe
// Assumes: Caller lets each send finish before the next one
// Notes:   Lines carry inverted data once the hold window ends
module vadf_enc_model
    import vadf_pkg::*;
(
    // Clock
    input  wire logic             sys_clk,
    // Frame output
    output logic                  frame_valid,
    output logic [ACF_W*NLAG-1:0] acf_flat
);
    realtime take_t;

    initial begin
        frame_valid = 1'b0;
        acf_flat    = '0;
        take_t      = 0.0;
    end

    // Extra strobe mid-pass probes the ignore path
    task automatic send(input logic [ACF_W*NLAG-1:0] acf, input bit extra,
                        input int gap);
        @(posedge sys_clk);
        frame_valid <= 1'b1;
        acf_flat    <= acf;
        @(posedge sys_clk);
        take_t = $realtime;
        frame_valid <= 1'b0;
        repeat (4) @(posedge sys_clk);
        frame_valid <= extra;
        @(posedge sys_clk);
        frame_valid <= 1'b0;
        repeat (10) @(posedge sys_clk);
        // Never leave stale acf that a sloppy design could reuse
        acf_flat <= ~acf;
        repeat (gap) @(posedge sys_clk);
    endtask
endmodule

// >>> test/vadf_top_tb_top.sv
`timescale 1ns/1ps
// Purpose: Self-checking bench for the frame-rate voice activity core
// Assumes: Periodicity level held high, so no adaptation happens
// Notes:   Stationarity predicted only while the delayed average is zero
module vadf_top_tb_top
    import vadf_pkg::*;
;
    typedef struct {
        logic [ACC_W-1:0] energy;
        logic             raw;
        logic             speech;
        logic             stat;
        bit               stat_known;
    } vadf_exp_s;

    logic                  sys_clk;
    logic                  rst_n;
    logic                  pitch_seen;
    logic                  tone_seen;
    logic                  frame_valid;
    logic [ACF_W*NLAG-1:0] acf_flat;
    vadf_flags_s           flags;
    logic                  frame_done;
    logic [ACC_W-1:0]      filt_energy;
    vadf_exp_s             exp_q[$];
    int                    n_mismatch;
    int                    checks;
    logic [31:0]           rnd;
    int                    burst;
    int                    hang;
    int                    nframe;
    int                    seq1[17] = '{2, 3, 1, 0, 0, 1, 1, 1, 0,
                                        0, 0, 0, 0, 0, 1, 1, 1};
    int                    seq2[6]  = '{0, 1, 1, 1, 0, 0};

    vadf_top DUT (
        .sys_clk     (sys_clk),
        .rst_n       (rst_n),
        .frame_valid (frame_valid),
        .acf_flat    (acf_flat),
        .pitch_seen  (pitch_seen),
        .tone_seen   (tone_seen),
        .flags       (flags),
        .frame_done  (frame_done),
        .filt_energy (filt_energy)
    );

    vadf_enc_model enc (
        .sys_clk     (sys_clk),
        .frame_valid (frame_valid),
        .acf_flat    (acf_flat)
    );

    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end

    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return x[0] ? ((x >> 1) ^ 32'h8020_0003) : (x >> 1);
    endfunction

    task automatic check(input string what, input logic [ACC_W-1:0] seen,
                         input logic [ACC_W-1:0] expv);
        checks++;
        if (seen !== expv) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %0h seen %0h",
                     what, expv, seen);
        end
    endtask

    task automatic report_and_stop();
        $display("checks %0d n_mismatch %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // Kind 0 noise, 1 speech, 2 energy equal to threshold, 3 just above
    task automatic frame(input int kind, input bit extra);
        logic [ACF_W*NLAG-1:0] acf;
        longint                a1;
        longint                a2;
        longint                e;
        vadf_exp_s             x;
        for (int i = 3; i < NLAG; i++) begin
            rnd = lfsr(rnd);
            acf[ACF_W*i +: ACF_W] = ACF_W'($signed(rnd[17:0]));
        end
        rnd = lfsr(rnd);
        a1 = (kind == 0) ? 150000 : ((kind == 1) ? 0 : 100000);
        a2 = (kind >= 2) ? kind - 2 : longint'(rnd[7:0]);
        acf[31:0]  = 32'h0004_93E0;
        acf[63:32] = ACF_W'(a1);
        acf[95:64] = ACF_W'(a2);
        // Reset filter 6, -4, 1 leaves lags 3 to 8 without weight
        e = 6 * 300000 - 8 * a1 + 2 * a2;
        x.energy = ACC_W'(e);
        x.raw = (e > 1000000);
        burst = x.raw ? burst + 1 : 0;
        if (burst >= 3) begin
            hang = 5;
            burst = 3;
        end
        x.speech = x.raw || (hang >= 0);
        if (hang >= 0) begin
            hang--;
        end
        // Flat predictor gives the same distortion every frame
        x.stat = (nframe != 0);
        x.stat_known = (nframe < 4);
        nframe++;
        exp_q.push_back(x);
        @(posedge sys_clk);
        tone_seen <= rnd[9];
        enc.send(acf, extra, int'(rnd[12:10]));
    endtask

    task automatic drain();
        int n;
        n = 0;
        while (exp_q.size() != 0 && n < 40) begin
            @(posedge sys_clk);
            n++;
        end
        check("pending frames", ACC_W'(exp_q.size()), 72'h0);
        // A lost answer ends the run here
        if (exp_q.size() != 0) begin
            report_and_stop();
        end
    endtask

    always @(negedge sys_clk) begin
        vadf_exp_s e;
        longint    lat;
        if (frame_done === 1'b1) begin
            if (exp_q.size() == 0) begin
                check("spare frame_done", 72'h1, 72'h0);
            end else begin
                e = exp_q.pop_front();
                lat = longint'(($realtime - enc.take_t) * 10.0);
                check("latency", ACC_W'(lat), 72'hE29);
                check("filt_energy", filt_energy, e.energy);
                check("raw_speech", ACC_W'(flags.raw_speech),
                      ACC_W'(e.raw));
                check("speech", ACC_W'(flags.speech),
                      ACC_W'(e.speech));
                if (e.stat_known) begin
                    check("stationary", ACC_W'(flags.stationary),
                          ACC_W'(e.stat));
                end
            end
        end
    end

    initial begin
        rst_n = 1'b0;
        pitch_seen = 1'b1;
        tone_seen = 1'b0;
        n_mismatch = 0;
        checks = 0;
        rnd = 32'h743C19D2;
        burst = 0;
        hang = -1;
        nframe = 0;
        repeat (4) @(posedge sys_clk);
        rst_n <= 1'b1;
        foreach (seq1[i]) begin
            frame(seq1[i], i == 3);
        end
        drain();
        $display("test hangover, threshold edge and ignored strobe done");
        // Second reset must clear history, hangover and stored distortion
        @(posedge sys_clk);
        rst_n <= 1'b0;
        @(posedge sys_clk);
        rst_n <= 1'b1;
        burst = 0;
        hang = -1;
        nframe = 0;
        foreach (seq2[i]) begin
            frame(seq2[i], 1'b0);
        end
        drain();
        $display("test restart after mid-run reset done");
        report_and_stop();
    end
endmodule
